// *** rtl/vim_arbiter.sv ***
/*
 * Two-level fixed-order arbiter: high level first, lowest order within a level.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module vim_arbiter (
    input wire logic [vim_pkg::NUM_SRC-1:0] req,
    input wire logic [vim_pkg::NUM_SRC-1:0] prio,
    input wire logic allow_low,
    input wire logic allow_high,
    output logic found,
    output logic [vim_pkg::ORDER_W-1:0] order,
    output logic level
);
    import vim_pkg::*;

    // returns {hit, index of lowest set bit}
    function automatic logic [ORDER_W:0] lowest_set(input logic [NUM_SRC-1:0] v);
        logic hit;
        logic [ORDER_W-1:0] idx;
        hit = 1'b0;
        idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                hit = 1'b1;
                idx = ORDER_W'(i);
            end
        end
        return {hit, idx};
    endfunction

    wire logic [NUM_SRC-1:0] hi_vec = req & prio & {NUM_SRC{allow_high}};
    wire logic [NUM_SRC-1:0] lo_vec = req & ~prio & {NUM_SRC{allow_low}};
    wire logic [ORDER_W:0] hi_pick = lowest_set(hi_vec);
    wire logic [ORDER_W:0] lo_pick = lowest_set(lo_vec);

    // a high-level request always beats any low-level one
    assign found = hi_pick[ORDER_W] | lo_pick[ORDER_W];
    assign level = hi_pick[ORDER_W];
    assign order = hi_pick[ORDER_W] ? hi_pick[ORDER_W-1:0] : lo_pick[ORDER_W-1:0];

endmodule

// *** rtl/vim_enable_map.sv ***
/*
 * Vectored interrupt enable map: interrupt_enable register, source gating,
 * two-level arbitration, handler nesting and the vector request to the core.
 * Assumes pending flags, priority bits and the extended enables come from
 * logic on sys_clk, and that the core pulses vec_ack when it vectors and
 * vec_return when a handler returns.
 */
`timescale 1ns/1ps
module vim_enable_map (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic sfr_bit_wr,
    input wire logic [7:0] sfr_bit_addr,
    input wire logic sfr_bit_wdata,
    input wire logic [7:0] timer_ctrl_reg,
    input wire logic [7:0] priority_reg,
    input wire logic uart_zero_rx_flag,
    input wire logic uart_zero_tx_flag,
    input wire logic timer_two_low_overflow,
    input wire logic timer_two_high_overflow,
    input wire logic spi_transfer_done,
    input wire logic spi_write_collision,
    input wire logic spi_mode_fault,
    input wire logic spi_receive_overrun,
    input wire logic [vim_pkg::EXT_HI:vim_pkg::EXT_LO] ext_src_pending,
    input wire logic [vim_pkg::EXT_HI:vim_pkg::EXT_LO] ext_src_enable,
    input wire logic [vim_pkg::EXT_HI:vim_pkg::EXT_LO] ext_src_priority,
    input wire logic vec_ack,
    input wire logic vec_return,
    output logic vec_req,
    output logic [vim_pkg::VEC_W-1:0] vec_addr,
    output logic [vim_pkg::ORDER_W-1:0] vec_order,
    output logic vec_high,
    output logic [7:0] interrupt_enable,
    output logic [vim_pkg::NUM_SRC-1:0] src_pending,
    output logic handler_low_active,
    output logic handler_high_active
);
    import vim_pkg::*;

    // state
    logic [7:0] enreg_r;
    logic [7:0] enreg_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [NUM_SRC-1:0] pend_r;
    vim_req_t req_r;
    vim_req_t req_nxt;
    vim_svc_t svc_r;
    vim_svc_t svc_nxt;
    logic [VEC_W-1:0] addr_r;
    logic [VEC_W-1:0] addr_nxt;
    logic [ORDER_W-1:0] order_r;
    logic [ORDER_W-1:0] order_nxt;
    logic high_r;
    logic high_nxt;
    // registered copies of the status outputs
    logic vec_req_r;
    logic vec_req_nxt;
    logic low_active_r;
    logic low_active_nxt;
    logic high_active_r;
    logic high_active_nxt;

    // enable-register field names
    wire logic global_irq_enable = enreg_r[IEB_GLOBAL];
    wire logic spi_irq_enable = enreg_r[IEB_SPI];
    wire logic timer_two_irq_enable = enreg_r[IEB_T2];
    wire logic uart_zero_irq_enable = enreg_r[IEB_UART0];
    wire logic timer_one_irq_enable = enreg_r[IEB_T1];
    wire logic ext_line_one_enable = enreg_r[IEB_EXT1];
    wire logic timer_zero_irq_enable = enreg_r[IEB_T0];
    wire logic ext_line_zero_enable = enreg_r[IEB_EXT0];

    // pending flags held in the timer control register, plus ext_one_priority from the priority register
    wire logic ext_zero_pending = timer_ctrl_reg[TCB_EXT0_PEND];
    wire logic ext_one_pending = timer_ctrl_reg[TCB_EXT1_PEND];
    wire logic timer_zero_overflow_flag = timer_ctrl_reg[TCB_T0_OVF];
    wire logic timer_one_overflow_flag = timer_ctrl_reg[TCB_T1_OVF];
    wire logic ext_one_priority = priority_reg[PRB_EXT1];

    // register access decode
    // the eight bit addresses from the byte address upward pick one enable bit each
    wire logic en_byte_hit = (sfr_addr == EN_REG_ADDR);
    wire logic en_byte_wr = sfr_wr & en_byte_hit;
    wire logic en_bit_hit = (sfr_bit_addr[7:BIT_IDX_W] == EN_REG_ADDR[7:BIT_IDX_W]);
    wire logic en_bit_wr = sfr_bit_wr & en_bit_hit;
    wire logic [BIT_IDX_W-1:0] en_bit_idx = sfr_bit_addr[BIT_IDX_W-1:0];

    // per-order pending, enable and priority vectors
    logic [NUM_SRC-1:0] pend_w;
    logic [NUM_SRC-1:0] en_w;
    logic [NUM_SRC-1:0] prio_w;

    assign pend_w[ORD_EXT0] = ext_zero_pending;
    assign pend_w[ORD_T0] = timer_zero_overflow_flag;
    assign pend_w[ORD_EXT1] = ext_one_pending;
    assign pend_w[ORD_T1] = timer_one_overflow_flag;
    assign pend_w[ORD_UART0] = uart_zero_rx_flag | uart_zero_tx_flag;
    assign pend_w[ORD_T2] = timer_two_low_overflow | timer_two_high_overflow;
    // all four serial-peripheral causes share one request and one mask
    assign pend_w[ORD_SPI] = spi_transfer_done | spi_write_collision
        | spi_mode_fault | spi_receive_overrun;
    assign pend_w[EXT_HI:EXT_LO] = ext_src_pending;

    assign en_w[ORD_EXT0] = ext_line_zero_enable;
    assign en_w[ORD_T0] = timer_zero_irq_enable;
    assign en_w[ORD_EXT1] = ext_line_one_enable;
    assign en_w[ORD_T1] = timer_one_irq_enable;
    assign en_w[ORD_UART0] = uart_zero_irq_enable;
    assign en_w[ORD_T2] = timer_two_irq_enable;
    assign en_w[ORD_SPI] = spi_irq_enable;
    assign en_w[EXT_HI:EXT_LO] = ext_src_enable;

    // the low seven priority bits line up with orders zero to six
    assign prio_w[ORD_SPI:ORD_EXT0] = {priority_reg[ORD_SPI:PRB_EXT1 + 1],
        ext_one_priority, priority_reg[PRB_EXT1 - 1:ORD_EXT0]};
    assign prio_w[EXT_HI:EXT_LO] = ext_src_priority;

    // gating and arbitration
    logic [NUM_SRC-1:0] gated_w;
    logic found_w;
    logic [ORDER_W-1:0] order_w;
    logic level_w;

    vim_src_gate u_gate (
        .pend(pend_w),
        .en(en_w),
        .global_en(global_irq_enable),
        .req(gated_w)
    );

    // nesting decides which levels may still be taken
    wire logic allow_low = (svc_r == VIM_SVC_NONE);
    wire logic allow_high = (svc_r == VIM_SVC_NONE) | (svc_r == VIM_SVC_LOW);

    vim_arbiter u_arb (
        .req(gated_w),
        .prio(prio_w),
        .allow_low(allow_low),
        .allow_high(allow_high),
        .found(found_w),
        .order(order_w),
        .level(level_w)
    );

    // a request posted before its enable is cleared stays up until the core takes it,
    // so the handler may start with the enable already reading zero
    wire logic take_new = (req_r == VIM_REQ_IDLE) & found_w;
    wire logic acked = (req_r == VIM_REQ_POSTED) & vec_ack;

    // enable register next value; a bit write lands on top of a byte write
    always_comb begin
        enreg_nxt = enreg_r;
        if (en_byte_wr) begin
            enreg_nxt = sfr_wdata;
        end
        // the other seven bits keep their value on a bit write
        if (en_bit_wr) begin
            enreg_nxt[en_bit_idx] = sfr_bit_wdata;
        end
    end

    // reads of other addresses answer zero so they can be or-ed on the shared bus
    assign rdata_nxt = (sfr_rd & en_byte_hit) ? enreg_r : SFR_IDLE_DATA;

    // request handshake with the core
    always_comb begin
        req_nxt = req_r;
        addr_nxt = addr_r;
        order_nxt = order_r;
        high_nxt = high_r;
        case (req_r)
            VIM_REQ_IDLE: begin
                if (take_new) begin
                    req_nxt = VIM_REQ_POSTED;
                    addr_nxt = vector_of(order_w);
                    order_nxt = order_w;
                    high_nxt = level_w;
                end
            end
            VIM_REQ_POSTED: begin
                if (vec_ack) begin
                    req_nxt = VIM_REQ_IDLE;
                end
            end
            default: begin
                req_nxt = VIM_REQ_IDLE;
            end
        endcase
    end

    // handler nesting: a return unwinds first, then an acknowledge nests
    always_comb begin
        svc_nxt = svc_r;
        if (vec_return) begin
            case (svc_r)
                VIM_SVC_HIGH_OVER_LOW: svc_nxt = VIM_SVC_LOW;
                VIM_SVC_HIGH: svc_nxt = VIM_SVC_NONE;
                VIM_SVC_LOW: svc_nxt = VIM_SVC_NONE;
                default: svc_nxt = VIM_SVC_NONE;
            endcase
        end
        if (acked) begin
            case (svc_nxt)
                VIM_SVC_NONE: svc_nxt = high_r ? VIM_SVC_HIGH : VIM_SVC_LOW;
                VIM_SVC_LOW: svc_nxt = high_r ? VIM_SVC_HIGH_OVER_LOW : VIM_SVC_LOW;
                default: svc_nxt = svc_nxt;
            endcase
        end
    end

    // status decoded ahead of the flops so each output leaves a register
    assign vec_req_nxt = (req_nxt == VIM_REQ_POSTED);
    assign low_active_nxt = (svc_nxt == VIM_SVC_LOW) | (svc_nxt == VIM_SVC_HIGH_OVER_LOW);
    assign high_active_nxt = (svc_nxt == VIM_SVC_HIGH) | (svc_nxt == VIM_SVC_HIGH_OVER_LOW);

    // own block; these track the state flops edge for edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vec_req_r <= 1'b0;
            low_active_r <= 1'b0;
            high_active_r <= 1'b0;
        end else begin
            vec_req_r <= vec_req_nxt;
            low_active_r <= low_active_nxt;
            high_active_r <= high_active_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            enreg_r <= EN_REG_RESET;
            rdata_r <= SFR_IDLE_DATA;
        end else begin
            enreg_r <= enreg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // raw pending flags are mirrored whatever the enables say
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend_r <= '0;
        end else begin
            pend_r <= pend_w;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_r <= VIM_REQ_IDLE;
            addr_r <= RESET_VECTOR;
            order_r <= '0;
            high_r <= 1'b0;
            svc_r <= VIM_SVC_NONE;
        end else begin
            req_r <= req_nxt;
            addr_r <= addr_nxt;
            order_r <= order_nxt;
            high_r <= high_nxt;
            svc_r <= svc_nxt;
        end
    end

    // outputs straight from flip-flops
    assign sfr_rdata = rdata_r;
    assign interrupt_enable = enreg_r;
    assign src_pending = pend_r;
    assign vec_req = vec_req_r;
    assign vec_addr = addr_r;
    assign vec_order = order_r;
    assign vec_high = high_r;
    assign handler_low_active = low_active_r;
    assign handler_high_active = high_active_r;

endmodule

// *** rtl/vim_pkg.sv ***
/*
 * Shared constants, types and the vector function for the vectored interrupt
 * enable map. Assumes one system clock and byte-wide special function
 * register access with bit addressing.
 */
package vim_pkg;

    // register map
    localparam logic [7:0] EN_REG_ADDR = 8'hA8;
    localparam logic [7:0] EN_REG_RESET = 8'h00;
    localparam logic [7:0] SFR_IDLE_DATA = 8'h00;
    localparam int BIT_IDX_W = 3;

    // interrupt_enable field positions
    localparam int IEB_EXT0 = 0;
    localparam int IEB_T0 = 1;
    localparam int IEB_EXT1 = 2;
    localparam int IEB_T1 = 3;
    localparam int IEB_UART0 = 4;
    localparam int IEB_T2 = 5;
    localparam int IEB_SPI = 6;
    localparam int IEB_GLOBAL = 7;

    // timer_ctrl_reg pending flag positions
    localparam int TCB_EXT0_PEND = 1;
    localparam int TCB_EXT1_PEND = 3;
    localparam int TCB_T0_OVF = 5;
    localparam int TCB_T1_OVF = 7;

    // priority_reg position of ext_one_priority
    localparam int PRB_EXT1 = 2;

    // arbitration orders
    localparam int NUM_SRC = 21;
    localparam int ORDER_W = 5;
    localparam int ORD_EXT0 = 0;
    localparam int ORD_T0 = 1;
    localparam int ORD_EXT1 = 2;
    localparam int ORD_T1 = 3;
    localparam int ORD_UART0 = 4;
    localparam int ORD_T2 = 5;
    localparam int ORD_SPI = 6;
    localparam int EXT_LO = 7;
    localparam int EXT_HI = 20;
    localparam int RESERVED_ORDER = 17;

    // code vectors
    localparam int VEC_W = 16;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int VEC_SHIFT = 3;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    typedef enum logic {
        VIM_REQ_IDLE,
        VIM_REQ_POSTED
    } vim_req_t;

    typedef enum logic [1:0] {
        VIM_SVC_NONE,
        VIM_SVC_LOW,
        VIM_SVC_HIGH,
        VIM_SVC_HIGH_OVER_LOW
    } vim_svc_t;

    // each order slot is eight bytes above the previous one
    function automatic logic [15:0] vector_of(input logic [4:0] order);
        logic [15:0] wide;
        wide = {11'h000, order};
        return VEC_BASE + (wide << VEC_SHIFT);
    endfunction

endpackage

// *** rtl/vim_src_gate.sv ***
/*
 * Per-source request gating: pending flag, own enable and global enable.
 * Assumes flags and enables come from logic on the same clock.
 */
`timescale 1ns/1ps
module vim_src_gate (
    input wire logic [vim_pkg::NUM_SRC-1:0] pend,
    input wire logic [vim_pkg::NUM_SRC-1:0] en,
    input wire logic global_en,
    output logic [vim_pkg::NUM_SRC-1:0] req
);
    import vim_pkg::*;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            if (g == RESERVED_ORDER) begin : g_rsv
                // the reserved slot has no source behind it
                assign req[g] = 1'b0;
            end else begin : g_live
                assign req[g] = pend[g] & en[g] & global_en;
            end
        end
    endgenerate

endmodule

// *** verification/tb.sv ***
/* Self-checking bench: a table of single-source cases, then registers,
   nesting, a held vector and a mid-run reset. Assumes vim_core_model beside it. */
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, (exp), (got)); \
    end \
end
module tb;
    import vim_pkg::*;
    typedef struct packed {
        logic [7:0] en;
        logic [4:0] src;
        logic [1:0] alt;
        logic req;
    } vim_row_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_wr = 1'b0, ret_go = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rd, sfr_rdata, interrupt_enable;
    logic [20:0] pend = 21'h0, prio = 21'h0, src_pending;
    logic [1:0] alt = 2'h0;
    logic [13:0] ext_en = 14'h3FFF;
    logic [3:0] ack_delay = 4'h0;
    logic vec_req, vec_high, vec_ack, vec_return, handler_low_active, handler_high_active;
    logic [15:0] vec_addr;
    logic [4:0] vec_order;
    int err_count = 0, check_count = 0, k;
    vim_row_t r;
    // enable value, order, flag variant, request expected
    vim_row_t rows [23] = '{16'h8101, 16'h7F00, 16'hFE00, 16'h8209, 16'hFD08, 16'h8411, 16'hFB10, 16'h8819,
        16'hF718, 16'h9021, 16'h9023, 16'hEF22, 16'hA029, 16'hA02B, 16'hDF2A, 16'hC031, 16'hC033,
        16'hC035, 16'hC037, 16'hBF36, 16'h80A1, 16'h8088, 16'h8049};
    vim_enable_map u_dut (
        .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_addr),
        .sfr_bit_wdata(sfr_wdata[0]), .priority_reg({1'b0, prio[6:0]}),
        .timer_ctrl_reg({pend[3], 1'b0, pend[1], 1'b0, pend[2], 1'b0, pend[0], 1'b0}),
        .uart_zero_rx_flag(pend[4] && alt == 2'h0), .uart_zero_tx_flag(pend[4] && alt != 2'h0),
        .timer_two_low_overflow(pend[5] && alt == 2'h0), .timer_two_high_overflow(pend[5] && alt != 2'h0),
        .spi_transfer_done(pend[6] && alt == 2'h0), .spi_write_collision(pend[6] && alt == 2'h1),
        .spi_mode_fault(pend[6] && alt == 2'h2), .spi_receive_overrun(pend[6] && alt == 2'h3),
        .ext_src_pending(pend[20:7]), .ext_src_enable(ext_en), .ext_src_priority(prio[20:7]),
        .vec_ack(vec_ack), .vec_return(vec_return), .vec_req(vec_req), .vec_addr(vec_addr),
        .vec_order(vec_order), .vec_high(vec_high), .interrupt_enable(interrupt_enable),
        .src_pending(src_pending), .handler_low_active(handler_low_active),
        .handler_high_active(handler_high_active)
    );
    vim_core_model u_core (.sys_clk(sys_clk), .rst(rst), .vec_req(vec_req), .ack_delay(ack_delay),
        .ret_go(ret_go), .vec_ack(vec_ack), .vec_return(vec_return));
    always #2.5 sys_clk = ~sys_clk;
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    // kind 0 byte write, 1 bit write, 2 read; strobes drop for a cycle between accesses
    task automatic acc(input logic [1:0] kind, input logic [7:0] addr, input logic [7:0] data);
        sfr_addr = addr;
        sfr_wdata = data;
        sfr_wr = kind == 2'h0;
        sfr_bit_wr = kind == 2'h1;
        sfr_rd = kind == 2'h2;
        tick();
        rd = sfr_rdata;
        sfr_wr = 1'b0;
        sfr_bit_wr = 1'b0;
        sfr_rd = 1'b0;
        tick();
    endtask
    // wait out the ack, then optionally return from one handler
    task automatic finish_isr(input logic had);
        for (k = 0; k < 16 && vec_req === 1'b1; k++) tick();
        `CHK("ack taken", vec_req, 1'b0)
        if (had) begin
            ret_go = 1'b1;
            tick();
            ret_go = 1'b0;
            tick();
            tick();
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            acc(2'h0, 8'hA8, r.en);
            alt = r.alt;
            pend = 21'h1 << r.src;
            tick();
            `CHK("vec_req", vec_req, r.req)
            `CHK("src_pending", src_pending, pend)
            if (r.req) `CHK("vec_addr", vec_addr, 16'h0003 + {8'h00, r.src, 3'h0})
            if (r.req) `CHK("vec_high", vec_high, 1'b0)
            pend = 21'h0;
            finish_isr(r.req);
            $display("row %0d done", i);
        end
        acc(2'h0, 8'hA8, 8'h5A);
        acc(2'h2, 8'hA8, 8'h00);
        `CHK("read", rd, 8'h5A)
        acc(2'h1, 8'hAF, 8'h01);
        acc(2'h1, 8'hA9, 8'h00);
        acc(2'h0, 8'hA9, 8'hFF);
        acc(2'h2, 8'hA8, 8'h00);
        `CHK("bit writes", rd, 8'hD8)
        acc(2'h2, 8'hB8, 8'h00);
        `CHK("unmapped read", rd, 8'h00)
        ext_en = 14'h0;
        acc(2'h0, 8'hA8, 8'h80);
        pend = 21'h200;
        tick();
        `CHK("ext masked", vec_req, 1'b0)
        pend = 21'h0;
        ext_en = 14'h3FFF;
        $display("register test done");
        ack_delay = 4'h2;
        acc(2'h0, 8'hA8, 8'h9F);
        pend = 21'h1C;
        prio = 21'h10;
        tick();
        `CHK("winner", {vec_req, vec_high, vec_order}, 7'h64)
        finish_isr(1'b0);
        pend = 21'h2;
        prio = 21'h2;
        repeat (3) tick();
        `CHK("high not preempted", vec_req, 1'b0)
        pend = 21'h0;
        finish_isr(1'b1);
        pend = 21'h1;
        prio = 21'h0;
        tick();
        finish_isr(1'b0);
        pend = 21'h9;
        prio = 21'h8;
        tick();
        `CHK("preempt", {vec_req, vec_high, vec_order}, 7'h63)
        pend = 21'h0;
        finish_isr(1'b0);
        `CHK("nested", {handler_high_active, handler_low_active}, 2'h3)
        finish_isr(1'b1);
        finish_isr(1'b1);
        `CHK("unwound", {handler_high_active, handler_low_active}, 2'h0)
        $display("nesting test done");
        ack_delay = 4'h6;
        acc(2'h0, 8'hA8, 8'h81);
        pend = 21'h1;
        tick();
        pend = 21'h0;
        acc(2'h0, 8'hA8, 8'h00);
        `CHK("held vector", {vec_req, vec_addr}, 17'h10003)
        finish_isr(1'b1);
        $display("hold test done");
        acc(2'h0, 8'hA8, 8'hC3);
        rst = 1'b1;
        repeat (2) tick();
        rst = 1'b0;
        tick();
        `CHK("reset state", {interrupt_enable, vec_req, vec_addr}, 25'h0)
        $display("reset test done");
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_count++;
        print_verdict();
    end
endmodule

// *** verification/vim_core_model.sv ***
/* Behavioural processor core: acks a posted vector ack_delay + 1 cycles after vec_req rises,
   and returns from a handler when ret_go is raised. Assumes sys_clk and rst. */
`timescale 1ns/1ps
module vim_core_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic vec_req,
    input wire logic [3:0] ack_delay,
    input wire logic ret_go,
    output logic vec_ack,
    output logic vec_return
);
    logic [3:0] wait_r;
    // ack only while posted, one cycle wide, so a slow core is no kinder
    wire logic ack_nxt = vec_req && !vec_ack && wait_r == ack_delay;
    always_ff @(posedge sys_clk) begin
        wait_r <= (rst || !vec_req || vec_ack) ? 4'h0 : wait_r + 4'h1;
        vec_ack <= !rst && ack_nxt;
        vec_return <= !rst && ret_go;
    end
endmodule

// *** verification/vim_enable_map_properties.sv ***
/* Port checker for vim_enable_map, attached by bind.
   Assumes one clock, sys_clk, and synchronous active-high rst. */
`timescale 1ns/1ps
module vim_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic vec_ack,
    input wire logic vec_return,
    input wire logic vec_req,
    input wire logic [15:0] vec_addr,
    input wire logic [4:0] vec_order,
    input wire logic vec_high,
    input wire logic [7:0] interrupt_enable,
    input wire logic handler_low_active,
    input wire logic handler_high_active
);
    wire logic [15:0] slot_addr = 16'h0003 + {8'h00, vec_order, 3'h0};
    wire logic en_read = sfr_rd && sfr_addr == 8'hA8;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    hold_until_ack_a:
    assert property (vec_req && !vec_ack |=> vec_req && $stable(vec_addr) && $stable(vec_high))
        else $error("posted vector moved before ack");
    drop_after_ack_a:
    assert property (vec_req && vec_ack |=> !vec_req)
        else $error("request kept after ack");
    vector_slot_a:
    assert property (vec_req |-> vec_addr == slot_addr)
        else $error("vector off its slot");
    no_reserved_a:
    assert property (vec_req |-> vec_order != 5'h11 && vec_order <= 5'h14)
        else $error("reserved order posted");
    global_gate_a:
    assert property (!vec_req && !interrupt_enable[7] |=> !vec_req)
        else $error("request with global enable clear");
    high_block_a:
    assert property (handler_high_active && !vec_return && !vec_req |=> !vec_req)
        else $error("high handler preempted");
    low_only_high_a:
    assert property (handler_low_active && !vec_return && !vec_req |=> !vec_req || vec_high)
        else $error("low request inside low handler");
    read_data_a:
    assert property (en_read |=> sfr_rdata == $past(interrupt_enable))
        else $error("read data differs from register");
    read_idle_a:
    assert property (!en_read |=> sfr_rdata == 8'h00)
        else $error("read data not zero");
    cover property (vec_req && vec_ack);
    cover property (handler_low_active && handler_high_active);
    cover property (en_read ##1 sfr_rdata != 8'h00);
endmodule

bind vim_enable_map vim_checker u_chk (
    .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .vec_ack(vec_ack), .vec_return(vec_return), .vec_req(vec_req), .vec_addr(vec_addr),
    .vec_order(vec_order), .vec_high(vec_high), .interrupt_enable(interrupt_enable),
    .handler_low_active(handler_low_active), .handler_high_active(handler_high_active)
);
